// ---- hold_timer.sv ----
// Purpose: counts how long a level has been continuously high
// Assumes: level is synchronous to clk
// Notes: done stays high while level stays high after the count is reached
`timescale 1ns/100ps
module hold_timer #(
    parameter int COUNT = 50
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic level,
    output logic done
);

    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);

    logic [W-1:0] cnt_ff;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_ff <= '0;
        else if (!level)
            cnt_ff <= '0;
        else if (cnt_ff != LAST)
            cnt_ff <= cnt_ff + W'(1);
    end

    assign done = level && (cnt_ff == LAST);

endmodule : hold_timer

// ---- master_model.sv ----
// Purpose: host master model driving the interface lines
// Assumes: lines change just after rising edges
// Notes: a released bus A shows the inverse of its last value
`timescale 1ns/100ps
module master_model
    import slave_seq_pkg::*;
#(
    parameter int TIMEOUT = 12
) (
    input wire logic core_clk,
    input slave_lines_s slv,
    output master_lines_s mst
);
    slave_lines_s seen;
    initial mst = '0;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    // Samples at falling edges, returns at a rising edge
    task automatic wait_line(input logic sync, input logic lvl);
        for (int i = 0; i < TIMEOUT; i++)
        begin
            @(negedge core_clk);
            seen = slv;
            if ((sync ? slv.sync_in : slv.slave_in) === lvl)
                break;
        end
        tick(1);
    endtask : wait_line
    task automatic deselect();
        tick(1);
        mst.select_out <= 1'h0;
        mst.bus_a <= ~mst.bus_a;
        mst.bus_a_perr <= 1'h0;
        wait_line(1'h0, 1'h0);
        tick(2);
    endtask : deselect
    task automatic select(input logic [7:0] a, input logic pe,
        output int tries);
        tries = 0;
        do
        begin
            tries++;
            tick(1);
            mst.bus_a <= a;
            mst.bus_a_perr <= pe && tries == 1;
            tick(1);
            mst.select_out <= 1'h1;
            wait_line(1'h0, 1'h1);
            if (seen.slave_in !== 1'h1)
                deselect();
        end
        while (seen.slave_in !== 1'h1 && tries < 2);
    endtask : select
    task automatic request(input logic [7:0] code, input logic pe,
        output logic [9:0] r);
        tick(1);
        mst.bus_a <= code;
        mst.bus_a_perr <= pe;
        tick(1);
        mst.master_out <= 1'h1;
        wait_line(1'h0, 1'h1);
        r = {seen.slave_in, seen.bus_b_oe, seen.bus_b};
        mst.master_out <= 1'h0;
        mst.bus_a <= ~code;
        mst.bus_a_perr <= 1'h0;
        wait_line(1'h0, 1'h0);
        tick(4);
    endtask : request
    task automatic busctl(input logic pe);
        tick(1);
        mst.bus_a <= 8'h5A;
        mst.bus_a_perr <= pe;
        tick(1);
        mst.sync_out <= 1'h1;
        wait_line(1'h1, 1'h1);
        mst.sync_out <= 1'h0;
        mst.bus_a_perr <= 1'h0;
        wait_line(1'h1, 1'h0);
    endtask : busctl
    task automatic hold_sync(input logic [7:0] code, input logic mo,
        input int n);
        tick(1);
        mst.bus_a <= code;
        mst.master_out <= mo;
        tick(4);
        mst.sync_out <= 1'h1;
        tick(n);
        mst.sync_out <= 1'h0;
        tick(4);
        mst.master_out <= 1'h0;
        tick(4);
    endtask : hold_sync
endmodule : master_model

// ---- slave_seq.sv ----
// Purpose: slave-side sequence control of the peripheral interface
// Assumes: master lines arrive synchronous to core_clk; parity checked
//          outside and flagged on bus_a_perr
// Notes: information transfer and data streaming are outside this block
//
// Behaviour
// - Restart or deselection after acknowledge means acknowledge rejected
// - Selection octet with parity error is not acted on
// - Request modifier with parity error ignored; master retries on time-out
// - Bad master status octet: not interpreted, transfer posted failed (never posted here: ack_given_ff is always clear in ST_SEL)
// - Bad bus control octet: not interpreted, parity error posted
// - Poll: matching slave drives its bit address on bus B
// - Settings query: slave drives response, raises slave in
// - Facility query: slave drives facility address, raises slave in
// - Slave interrupt query: slave drives interrupts octet, raises slave in
// - Selected slave drives select status and raises slave in, in the same cycle
// - Busy slave raises slave in alone, no address
// - Parity error on selection: no slave selected, slave in low
// - Selection held while select out high, dropped when it falls
// - Independent maintenance detection after 2 us continuous
// - Selective reset resets one slave and ends maintenance mode
// - Selective reset: slave drops slave in, waits 2 us before reset
`timescale 1ns/100ps
module slave_seq
    import slave_seq_pkg::*;
#(
    parameter logic [7:0] SLAVE_ADDR = 8'h01,
    parameter logic [7:0] REQ_XFR_SET = 8'h80,
    parameter logic [7:0] REQ_FAC_INT = 8'h40,
    parameter logic [7:0] REQ_SLV_INT = 8'h20,
    parameter logic [7:0] REQ_SEL_RESET = 8'h10
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input master_lines_s mst,
    input wire logic [7:0] pending_irq,
    input wire logic [7:0] fac_irq,
    input wire logic [7:0] xfr_settings,
    input wire logic [7:0] slave_irq_octet,
    input wire logic can_exchange,
    input wire logic xfr_fail_in,
    output slave_lines_s slv,
    output logic selected,
    output logic [7:0] facility_addr,
    output logic [7:0] bus_ctl_octet,
    output logic bus_ctl_valid,
    output logic ack_rejected,
    output logic [7:0] slave_status,
    output logic maint_mode,
    output logic slave_reset
);

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    seq_state_e state_ff;
    seq_state_e nxt_state;

    logic addr_hit;
    logic is_dir_req;
    logic poll_hit;
    logic maint_level;
    logic maint_done;
    logic selrst_level;
    logic selrst_done;
    logic ack_given_ff;
    logic selrst_ff;
    logic [7:0] stat_ff;

    assign addr_hit = (mst.bus_a & SLAVE_ADDR) != 8'h00;
    assign poll_hit = (pending_irq & mst.bus_a) != 8'h00;
    assign is_dir_req = (mst.bus_a == REQ_XFR_SET)
        || (mst.bus_a == REQ_FAC_INT) || (mst.bus_a == REQ_SLV_INT);

    // ----------------------------------------------------------------
    // Maintenance and selective reset detection
    // ----------------------------------------------------------------
    // Kept apart from the sequence machine so a hung machine can't mask it
    assign maint_level = mst.sync_out && !mst.select_out
        && !mst.master_out;

    hold_timer #(
        .COUNT(MAINT_MIN_CYC)
    ) u_maint_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .level(maint_level),
        .done(maint_done)
    );

    assign selrst_level = selrst_ff && mst.sync_out && mst.master_out;

    hold_timer #(
        .COUNT(RESET_MIN_CYC)
    ) u_selrst_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .level(selrst_level),
        .done(selrst_done)
    );

    // Selective reset octet latched in any cycle master out is high, select out low, no parity error
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            selrst_ff <= 1'b0;
        else if (!mst.master_out)
            selrst_ff <= 1'b0;
        else if (!mst.bus_a_perr && !mst.select_out
                 && mst.bus_a == REQ_SEL_RESET)
            selrst_ff <= 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            maint_mode <= 1'b0;
        else if (selrst_done)
            maint_mode <= 1'b0;
        else if (maint_done)
            maint_mode <= 1'b1;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            slave_reset <= 1'b0;
        else
            slave_reset <= selrst_done;
    end

    // ----------------------------------------------------------------
    // Sequence machine
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (mst.select_out)
                    nxt_state = ST_SEL;
                else if (mst.master_out)
                    nxt_state = ST_REQ;
            end
            ST_REQ:
            begin
                if (!mst.master_out)
                    nxt_state = ST_IDLE;
            end
            ST_SEL:
            begin
                // Bad or foreign selection octet leaves us silent
                if (!mst.select_out)
                    nxt_state = ST_IDLE;
                else if (!mst.bus_a_perr && addr_hit)
                    nxt_state = ST_SELACK;
            end
            ST_SELACK:
            begin
                if (!mst.select_out)
                    nxt_state = ST_DESEL;
                else if (mst.sync_out && !mst.master_out)
                    nxt_state = ST_CTL;
            end
            ST_CTL:
            begin
                if (!mst.select_out)
                    nxt_state = ST_DESEL;
                else
                    nxt_state = ST_ACK;
            end
            ST_ACK:
            begin
                if (!mst.select_out)
                    nxt_state = ST_DESEL;
                else if (!mst.sync_out)
                    nxt_state = ST_SELACK;
            end
            ST_DESEL:
            begin
                nxt_state = ST_IDLE;
            end
            default:
            begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // ----------------------------------------------------------------
    // Request handling: which reply is pending
    // ----------------------------------------------------------------
    logic req_ans_ff;
    logic [7:0] req_oct_ff;

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_ans_ff <= 1'b0;
            req_oct_ff <= 8'h00;
        end
        else if (state_ff != ST_REQ)
        begin
            req_ans_ff <= 1'b0;
            req_oct_ff <= 8'h00;
        end
        else if (!req_ans_ff && !mst.bus_a_perr)
        begin
            if (mst.bus_a == REQ_XFR_SET)
            begin
                req_ans_ff <= 1'b1;
                req_oct_ff <= xfr_settings;
            end
            else if (mst.bus_a == REQ_FAC_INT)
            begin
                req_ans_ff <= 1'b1;
                req_oct_ff <= fac_irq & mst.bus_a;
            end
            else if (mst.bus_a == REQ_SLV_INT)
            begin
                req_ans_ff <= 1'b1;
                req_oct_ff <= slave_irq_octet;
            end
            else if (!is_dir_req && mst.bus_a != REQ_SEL_RESET && poll_hit)
                req_oct_ff <= SLAVE_ADDR;
        end
    end

    // ----------------------------------------------------------------
    // Selection, bus control and status
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            facility_addr <= 8'h00;
        else if (state_ff == ST_SEL && nxt_state == ST_SELACK)
            facility_addr <= mst.bus_a & ~SLAVE_ADDR;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_ctl_octet <= 8'h00;
            bus_ctl_valid <= 1'b0;
        end
        else
        begin
            bus_ctl_valid <= 1'b0;
            if (state_ff == ST_CTL && !mst.bus_a_perr)
            begin
                bus_ctl_octet <= mst.bus_a;
                bus_ctl_valid <= 1'b1;
            end
        end
    end

    // Acknowledge counts as rejected if the master restarts or deselects
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ack_given_ff <= 1'b0;
        else if (state_ff == ST_ACK)
            ack_given_ff <= 1'b1;
        else if (state_ff == ST_SELACK && mst.master_out)
            ack_given_ff <= 1'b0;
        else if (state_ff == ST_IDLE)
            ack_given_ff <= 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            ack_rejected <= 1'b0;
        else
            ack_rejected <= ack_given_ff && state_ff == ST_SELACK
                && (nxt_state == ST_CTL || nxt_state == ST_DESEL);
    end

    // Status bits: set wins over the clear taken after status is shown
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            stat_ff <= 8'h00;
        else
        begin
            if (state_ff == ST_DESEL)
                stat_ff <= 8'h00;
            if (state_ff == ST_SEL && ack_given_ff
                && mst.bus_a_perr)
                stat_ff[STAT_XFR_FAIL_BIT] <= 1'b1;
            if (xfr_fail_in)
                stat_ff[STAT_XFR_FAIL_BIT] <= 1'b1;
            if (state_ff == ST_CTL && mst.bus_a_perr)
                stat_ff[STAT_CTL_PERR_BIT] <= 1'b1;
            if (ack_rejected)
                stat_ff[STAT_ACK_REJ_BIT] <= 1'b1;
        end
    end

    assign slave_status = stat_ff;

    // ----------------------------------------------------------------
    // Interface outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            slv <= '0;
        else
        begin
            slv <= '0;
            case (state_ff)
                ST_REQ:
                begin
                    // Octet goes out a cycle ahead of slave in
                    slv.bus_b <= req_oct_ff;
                    slv.bus_b_oe <= req_oct_ff != 8'h00 || req_ans_ff;
                    slv.slave_in <= req_ans_ff && slv.bus_b_oe;
                end
                ST_SELACK:
                begin
                    slv.bus_b <= can_exchange ? SLAVE_ADDR : 8'h00;
                    slv.bus_b_oe <= can_exchange;
                    slv.slave_in <= 1'b1;
                end
                ST_CTL, ST_ACK:
                begin
                    slv.bus_b <= bus_ctl_octet;
                    slv.bus_b_oe <= 1'b1;
                    slv.slave_in <= 1'b1;
                    slv.sync_in <= 1'b1;
                end
                default:
                begin
                    slv <= '0;
                end
            endcase
            if (selrst_level)
                slv.slave_in <= 1'b0;
        end
    end

    assign selected = state_ff == ST_SELACK || state_ff == ST_CTL
        || state_ff == ST_ACK;

endmodule : slave_seq

// ---- slave_seq_pkg.sv ----
// Purpose: shared constants and types for the slave sequence controller
// Assumes: 25 MHz core clock, all interface inputs synchronous
// Notes: octet values of request codes are parameters of the top module
package slave_seq_pkg;

    localparam int CLK_MHZ = 25;
    localparam int MAINT_MIN_US = 2;
    localparam int MAINT_MIN_CYC = MAINT_MIN_US * CLK_MHZ;
    localparam int RESET_MIN_US = 2;
    localparam int RESET_MIN_CYC = RESET_MIN_US * CLK_MHZ;

    // Slave status octet bit positions
    localparam int STAT_XFR_FAIL_BIT = 0;
    localparam int STAT_CTL_PERR_BIT = 1;
    localparam int STAT_ACK_REJ_BIT = 2;

    typedef enum logic [6:0]
    {
        ST_IDLE = 7'h01,
        ST_REQ = 7'h02,
        ST_SEL = 7'h04,
        ST_SELACK = 7'h08,
        ST_CTL = 7'h10,
        ST_ACK = 7'h20,
        ST_DESEL = 7'h40
    } seq_state_e;

    typedef struct packed
    {
        logic select_out;
        logic master_out;
        logic sync_out;
        logic [7:0] bus_a;
        logic bus_a_perr;
    } master_lines_s;

    typedef struct packed
    {
        logic slave_in;
        logic sync_in;
        logic [7:0] bus_b;
        logic bus_b_oe;
    } slave_lines_s;

endpackage : slave_seq_pkg

// ---- slave_seq_props.sv ----
// Purpose: port-level timing checks on the slave sequence controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes: sync_cnt saturates, so very long holds stay harmless
`timescale 1ns/100ps
module slave_seq_props
    import slave_seq_pkg::*;
#(
    parameter logic [7:0] SLAVE_ADDR = 8'h01
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input master_lines_s mst,
    input wire logic can_exchange,
    input slave_lines_s slv,
    input wire logic selected,
    input wire logic maint_mode,
    input wire logic slave_reset
);
    int sync_cnt;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Sync hold counter
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sync_cnt <= 0;
        else if (!mst.sync_out || mst.select_out)
            sync_cnt <= 0;
        else if (sync_cnt < 200)
            sync_cnt <= sync_cnt + 1;
    end
    a_perr_no_select: assert property (
        !selected && mst.bus_a_perr |=> !selected)
        else $error("selected on a bad selection octet");
    a_desel_drops: assert property (
        !mst.select_out |=> !selected)
        else $error("selection kept after select out fell");
    a_sel_answers: assert property (
        $rose(selected) |=> slv.slave_in)
        else $error("no slave in after selection");
    a_select_status: assert property (
        $rose(slv.slave_in) && selected |-> slv.bus_b_oe == can_exchange
        && (!can_exchange || slv.bus_b == SLAVE_ADDR))
        else $error("select status does not match busy state");
    a_maint_early: assert property (
        $rose(maint_mode) |-> sync_cnt >= MAINT_MIN_CYC - 1)
        else $error("maintenance entered too soon");
    a_maint_late: assert property (
        sync_cnt == MAINT_MIN_CYC + 4 && !mst.master_out |-> maint_mode)
        else $error("maintenance not entered");
    a_reset_early: assert property (
        $rose(slave_reset) |-> sync_cnt >= RESET_MIN_CYC - 1)
        else $error("selective reset acted too soon");
    a_reset_ends_maint: assert property (
        $rose(slave_reset) |-> ##[0:2] !maint_mode)
        else $error("maintenance kept through selective reset");
    a_reset_quiet_in: assert property (
        slave_reset && $past(slave_reset) |-> !slv.slave_in)
        else $error("slave in high during selective reset");
    cover property ($rose(maint_mode));
    cover property ($rose(slave_reset));
    cover property ($rose(slv.slave_in) && selected && !slv.bus_b_oe);
endmodule : slave_seq_props

bind slave_seq slave_seq_props #(.SLAVE_ADDR(SLAVE_ADDR)) i_props (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .mst(mst),
    .can_exchange(can_exchange),
    .slv(slv),
    .selected(selected),
    .maint_mode(maint_mode),
    .slave_reset(slave_reset)
);

// ---- tb.sv ----
// Purpose: self-checking bench for the slave sequence controller
// Assumes: master model drives the interface lines
// Notes: pulse outputs are caught by an edge watcher
`timescale 1ns/100ps
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb;
    import slave_seq_pkg::*;
    localparam logic [7:0] ADDR = 8'h04;
    localparam logic [7:0] FAC = 8'h10;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    master_lines_s mst;
    slave_lines_s slv;
    logic [7:0] pending_irq = 8'h02;
    logic can_exchange = 1'h1;
    logic [7:0] fac_irq = 8'h6C;
    logic [7:0] xfr_settings = 8'hC3;
    logic [7:0] slave_irq_octet = 8'h96;
    logic xfr_fail_in = 1'h0;
    logic selected, bus_ctl_valid, ack_rejected, maint_mode, slave_reset;
    logic [7:0] facility_addr, bus_ctl_octet, slave_status;
    logic seen_ctl = 1'h0, seen_rej = 1'h0, seen_rst = 1'h0;
    int miscompares = 0;
    int num_checks = 0;
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        if (bus_ctl_valid === 1'h1) seen_ctl <= 1'h1;
        if (ack_rejected === 1'h1) seen_rej <= 1'h1;
        if (slave_reset === 1'h1) seen_rst <= 1'h1;
    end
    master_model #(.TIMEOUT(12)) i_mst (.core_clk(core_clk), .slv(slv),
        .mst(mst));
    slave_seq #(.SLAVE_ADDR(ADDR)) i_dut (.core_clk(core_clk),
        .rst_b(rst_b), .mst(mst), .pending_irq(pending_irq),
        .fac_irq(fac_irq), .xfr_settings(xfr_settings),
        .slave_irq_octet(slave_irq_octet), .can_exchange(can_exchange),
        .xfr_fail_in(xfr_fail_in), .slv(slv),
        .selected(selected), .facility_addr(facility_addr),
        .bus_ctl_octet(bus_ctl_octet), .bus_ctl_valid(bus_ctl_valid),
        .ack_rejected(ack_rejected), .slave_status(slave_status),
        .maint_mode(maint_mode), .slave_reset(slave_reset));
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_select(input logic ce);
        int tries;
        @(posedge core_clk);
        can_exchange <= ce;
        i_mst.select(ADDR | FAC, 1'h0, tries);
        @(negedge core_clk);
        `CHK({slv.slave_in, slv.bus_b_oe}, {1'h1, ce})
        if (ce) `CHK(slv.bus_b, ADDR)
        `CHK({selected, facility_addr}, {1'h1, FAC})
        i_mst.deselect();
        @(negedge core_clk);
        `CHK({selected, slv.slave_in}, 2'h0)
        // Later scenarios need a slave that is not busy
        @(posedge core_clk);
        can_exchange <= 1'h1;
    endtask : t_select
    task automatic t_perr();
        int tries;
        i_mst.select(ADDR, 1'h1, tries);
        `CHK(tries, 2)
        i_mst.deselect();
    endtask : t_perr
    task automatic t_ctl();
        int tries;
        i_mst.select(ADDR, 1'h0, tries);
        seen_ctl = 1'h0;
        i_mst.busctl(1'h1);
        @(negedge core_clk);
        `CHK(seen_ctl, 1'h0)
        `CHK(slave_status[STAT_CTL_PERR_BIT], 1'h1)
        i_mst.busctl(1'h0);
        @(negedge core_clk);
        `CHK(seen_ctl, 1'h1)
        `CHK(bus_ctl_octet, 8'h5A)
        @(posedge core_clk);
        xfr_fail_in <= 1'h1;
        @(posedge core_clk);
        xfr_fail_in <= 1'h0;
        @(negedge core_clk);
        `CHK(slave_status[STAT_XFR_FAIL_BIT], 1'h1)
        seen_rej = 1'h0;
        i_mst.busctl(1'h0);
        @(negedge core_clk);
        `CHK(seen_rej, 1'h1)
        `CHK(slave_status[STAT_ACK_REJ_BIT], 1'h1)
        i_mst.deselect();
    endtask : t_ctl
    task automatic t_req(input logic [7:0] code, input logic pe,
        input logic [9:0] exp);
        logic [9:0] r;
        i_mst.request(code, pe, r);
        `CHK(r[9:8], exp[9:8])
        if (exp[8]) `CHK(r[7:0], exp[7:0])
        @(negedge core_clk);
        `CHK(slv.slave_in, 1'h0)
    endtask : t_req
    task automatic t_hold(input logic sel, input int n, input logic exp);
        seen_rst = 1'h0;
        i_mst.hold_sync(sel ? i_dut.REQ_SEL_RESET : 8'h00, sel, n);
        @(negedge core_clk);
        `CHK(sel ? seen_rst : maint_mode, exp)
        if (sel && exp) `CHK(maint_mode, 1'h0)
    endtask : t_hold
    task automatic complete_run();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'h1;
        t_select(1'h1);
        t_select(1'h0);
        t_perr();
        t_ctl();
        t_req(i_dut.REQ_XFR_SET, 1'h0, {2'h3, 8'hC3});
        t_req(i_dut.REQ_FAC_INT, 1'h0, {2'h3, 8'h40});
        t_req(i_dut.REQ_SLV_INT, 1'h0, {2'h3, 8'h96});
        t_req(8'h02, 1'h0, {2'h1, ADDR});
        t_req(i_dut.REQ_XFR_SET, 1'h1, 10'h000);
        t_hold(1'h0, MAINT_MIN_CYC - 8, 1'h0);
        t_hold(1'h0, MAINT_MIN_CYC + 8, 1'h1);
        t_hold(1'h1, RESET_MIN_CYC - 8, 1'h0);
        t_hold(1'h1, RESET_MIN_CYC + 8, 1'h1);
        complete_run();
    end
    initial
    begin
        #(40 * 20000);
        miscompares++;
        complete_run();
    end
endmodule : tb
